//--- rtl/srfo_pkg.sv
package srfo_pkg;

    // Register map, byte addresses on the serial bus
    localparam logic [7:0] ADDR_MOTION_STATUS  = 8'h9E;
    localparam logic [7:0] ADDR_LIGHT0_LOW     = 8'hA4;
    localparam logic [7:0] ADDR_LIGHT0_HIGH    = 8'hA5;
    localparam logic [7:0] ADDR_LIGHT1_LOW     = 8'hA6;
    localparam logic [7:0] ADDR_LIGHT1_HIGH    = 8'hA7;
    localparam logic [7:0] ADDR_PROX_LOW       = 8'hB0;
    localparam logic [7:0] ADDR_PROX_HIGH      = 8'hB1;
    localparam logic [7:0] ADDR_BUFFER_COUNT   = 8'hB2;
    localparam logic [7:0] ADDR_NORTH_SAMPLE   = 8'hB3;
    localparam logic [7:0] ADDR_SOUTH_SAMPLE   = 8'hB4;
    localparam logic [7:0] ADDR_EAST_SAMPLE    = 8'hB5;
    localparam logic [7:0] ADDR_WEST_SAMPLE    = 8'hB6;

    // Motion status field positions
    localparam int BIT_OCCUPIED = 7;
    localparam int BIT_FULL     = 6;
    localparam int BIT_INVALID  = 5;
    localparam int BIT_IRQ      = 4;
    localparam int BIT_FRESH    = 3;

    // Value of every readout register after reset
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Dataset buffer geometry
    localparam int BUF_DEPTH = 32;
    localparam int PTR_W     = 5;
    localparam int CNT_W     = 6;
    localparam int SAMPLE_W  = 32;
    // Sample plus invalid flag plus end-of-event flag
    localparam int XFER_W    = 34;

    // Serial bus device address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h23;

    // Serial bus slave states
    typedef enum logic [3:0] {
        SB_IDLE, SB_ADDR, SB_ADDR_ACK, SB_REG, SB_REG_ACK,
        SB_WDATA, SB_WACK, SB_RDATA, SB_RACK
    } srfo_bus_st_t;

    // Motion detection states
    typedef enum logic {
        MOT_COLLECT, MOT_HOLD
    } srfo_mot_st_t;

endpackage

//--- rtl/srfo_xfer_if.sv
`timescale 1ns/100ps
`default_nettype none

// Dataset hand-over from the link side into the system domain
interface srfo_xfer_if
    import srfo_pkg::*;
    #(parameter int W = XFER_W) ();
    logic         valid;   // Word waiting
    logic         ready;   // Receiver takes it
    logic [W-1:0] data;    // Word itself

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

//--- rtl/srfo_link_capture.sv
`timescale 1ns/100ps
`default_nettype none

module srfo_link_capture
    import srfo_pkg::*;
    #(parameter int WIDTH = XFER_W) (
    // Link side
    input  wire logic             link_clk,
    input  wire logic             rst_b,
    input  wire logic             fe_valid,
    input  wire logic [WIDTH-1:0] fe_data,
    output logic                  fe_ready,
    // System side
    input  wire logic             clk_sys,
    srfo_xfer_if.src              xf
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain state: two-entry buffer and request toggle
    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;     // Buffer entries
        logic                  head;     // Oldest entry
        logic [1:0]            cnt;      // Entries held
        logic [WIDTH-1:0]      hold;     // Word offered across
        logic                  req;      // Toggles per offered word
        logic                  ack_s1;   // Ack synchroniser, stage 1
        logic                  ack_s2;   // Ack synchroniser, stage 2
        logic                  ready;    // Registered room flag
    } srfo_link_t;

    // System domain state: request sync and ack toggle
    typedef struct packed {
        logic req_s1;                    // Stage 1, read by stage 2 only
        logic req_s2;                    // Stage 2
        logic ack;                       // Toggles per taken word
    } srfo_sys_t;

    srfo_link_t l_reg, l_next;
    srfo_sys_t  s_reg, s_next;
    logic       push;                    // Word enters buffer
    logic       move;                    // Head goes to hold
    logic       busy;                    // Hold not yet taken

    ////////////////////////////////////////////////////////////////////////
    // Link side: fill buffer, offer one word at a time
    always_comb begin
        l_next        = l_reg;
        push          = fe_valid & l_reg.ready;
        busy          = l_reg.req ^ l_reg.ack_s2;
        move          = (l_reg.cnt != 2'd0) & ~busy;
        l_next.ack_s1 = s_reg.ack;
        l_next.ack_s2 = l_reg.ack_s1;
        // Write slot follows the old head and count
        if (push) begin
            l_next.slot[l_reg.head ^ l_reg.cnt[0]] = fe_data;
        end
        // Hold only changes while nothing is outstanding
        if (move) begin
            l_next.hold = l_reg.slot[l_reg.head];
            l_next.head = ~l_reg.head;
            l_next.req  = ~l_reg.req;
        end
        l_next.cnt   = l_reg.cnt + {1'b0, push} - {1'b0, move};
        l_next.ready = (l_next.cnt != 2'd2);
    end

    // Link registers
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            l_reg       <= '0;
            l_reg.ready <= 1'b1;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System side: word valid while toggles differ
    always_comb begin
        s_next        = s_reg;
        s_next.req_s1 = l_reg.req;
        s_next.req_s2 = s_reg.req_s1;
        if (xf.valid && xf.ready) begin
            s_next.ack = ~s_reg.ack;
        end
    end

    // System registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Hold is stable whenever valid shows, so it crosses as is
    assign xf.valid = s_reg.req_s2 ^ s_reg.ack;
    assign xf.data  = l_reg.hold;
    assign fe_ready = l_reg.ready;

endmodule

`default_nettype wire

//--- rtl/srfo_readout.sv
// Summary of operation
// - Status bit 7 shows buffer holds data
// - Status bit 6 shows buffer full
// - Status bit 5 set means data invalid
// - Status bit 4 mirrors motion interrupt
// - Status bit 3 set means fresh data
// - Two light results, low byte first, A4-A7
// - Proximity result: low byte, then three bits
// - Count register bits 5:0 give unread datasets
// - Each whole dataset read lowers count by one
// - Count reaching zero drops the interrupt
// - Drained buffer restarts detection without command
// - Buffer holds at most thirty-two datasets
// - Full buffer drops new datasets
// - Interrupt stays until buffer drained
`timescale 1ns/100ps
`default_nettype none

module srfo_readout
    import srfo_pkg::*;
    #(parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT) (
    // System clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // Serial bus pins, open drain
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_B,
    // Interrupt pin, open drain
    output logic             INT_OUT,
    output logic             INT_OE_B,
    // Motion front end, on its own clock
    input  wire logic        LINK_CLK,
    input  wire logic        FE_VALID,
    input  wire logic [31:0] FE_SAMPLE,
    input  wire logic        FE_INVALID,
    input  wire logic        FE_LAST,
    output logic             FE_READY,
    // Light and proximity results, system clock
    input  wire logic [15:0] LIGHT_CH0,
    input  wire logic [15:0] LIGHT_CH1,
    input  wire logic [10:0] PROX_RESULT,
    input  wire logic        RESULT_LOAD,
    // Detection running
    output logic             MOTION_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////
    // Whole module state
    typedef struct packed {
        logic [2:0]                          scl_p;    // Clock pin sync chain
        logic [2:0]                          sda_p;    // Data pin sync chain
        srfo_bus_st_t                        bus_st;   // Serial slave state
        logic [3:0]                          bit_cnt;  // Bits this byte
        logic [7:0]                          shift;    // Incoming byte
        logic [7:0]                          tx;       // Outgoing byte
        logic                                rw;       // Read transfer
        logic                                nack;     // Host refused byte
        logic [7:0]                          ptr;      // Register pointer
        logic                                sda_oe_b; // Data pin release
        logic [15:0]                         ch0;      // Light result 0
        logic [15:0]                         ch1;      // Light result 1
        logic [10:0]                         prox;     // Proximity result
        logic [BUF_DEPTH-1:0][SAMPLE_W-1:0] mem;      // Dataset storage
        logic [PTR_W-1:0]                    wr_ptr;   // Next free slot
        logic [PTR_W-1:0]                    rd_ptr;   // Oldest dataset
        logic [CNT_W-1:0]                    count;    // Unread datasets
        srfo_mot_st_t                        mot_st;   // Detection state
        logic                                irq;      // Motion interrupt
        logic                                fresh;    // Unread new data
        logic                                invalid;  // Last data unusable
        logic                                int_oe_b; // Interrupt release
        logic                                active;   // Detection running
    } srfo_state_t;

    srfo_state_t r_reg, r_next;

    // Pin events, taken from the second and third sync stages
    logic scl_high;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    // Read side effects
    logic       rd_fire;                  // A byte was fetched for the host
    logic [7:0] rd_addr;                  // Its address
    logic [7:0] rd_byte;                  // Its value
    // Dataset movement
    logic       take;                     // Word taken from link side
    logic       store;                    // Word written into storage
    logic       pop;                      // One dataset consumed
    logic [SAMPLE_W-1:0] in_sample;       // Incoming dataset
    logic       in_invalid;               // Its invalid flag
    logic       in_last;                  // Ends the motion event

    srfo_xfer_if #(.W(XFER_W)) xf ();

    ////////////////////////////////////////////////////////////////////////
    // Link side capture and clock crossing
    srfo_link_capture #(.WIDTH(XFER_W)) u_link (
        .link_clk (LINK_CLK),
        .rst_b    (RST_B),
        .fe_valid (FE_VALID),
        .fe_data  ({FE_LAST, FE_INVALID, FE_SAMPLE}),
        .fe_ready (FE_READY),
        .clk_sys  (CLK_SYS),
        .xf       (xf.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pointer step: the four sample bytes wrap onto themselves
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        if (p == ADDR_WEST_SAMPLE) begin
            ptr_step = ADDR_NORTH_SAMPLE;
        end else begin
            ptr_step = p + 8'h01;
        end
    endfunction

    // Read value of one register
    function automatic logic [7:0] reg_value(input srfo_state_t s,
                                             input logic [7:0]  a);
        logic [SAMPLE_W-1:0] head;
        head = s.mem[s.rd_ptr];
        case (a)
            ADDR_MOTION_STATUS: begin
                reg_value                = RST_BYTE;
                reg_value[BIT_OCCUPIED]  = (s.count != '0);
                reg_value[BIT_FULL]      = (s.count == CNT_W'(BUF_DEPTH));
                reg_value[BIT_INVALID]   = s.invalid;
                reg_value[BIT_IRQ]       = s.irq;
                reg_value[BIT_FRESH]     = s.fresh;
            end
            ADDR_LIGHT0_LOW:   reg_value = s.ch0[7:0];
            ADDR_LIGHT0_HIGH:  reg_value = s.ch0[15:8];
            ADDR_LIGHT1_LOW:   reg_value = s.ch1[7:0];
            ADDR_LIGHT1_HIGH:  reg_value = s.ch1[15:8];
            ADDR_PROX_LOW:     reg_value = s.prox[7:0];
            ADDR_PROX_HIGH:    reg_value = {5'h00, s.prox[10:8]};
            ADDR_BUFFER_COUNT: reg_value = {2'b00, s.count};
            // Samples come from the oldest unread dataset
            ADDR_NORTH_SAMPLE: reg_value = head[7:0];
            ADDR_SOUTH_SAMPLE: reg_value = head[15:8];
            ADDR_EAST_SAMPLE:  reg_value = head[23:16];
            ADDR_WEST_SAMPLE:  reg_value = head[31:24];
            // Unmapped addresses read as zero
            default:           reg_value = RST_BYTE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        r_next   = r_reg;
        rd_fire  = 1'b0;
        rd_addr  = r_reg.ptr;
        rd_byte  = reg_value(r_reg, r_reg.ptr);

        // Pins pass two stages before any logic looks at them
        r_next.scl_p = {r_reg.scl_p[1:0], SCL_IN};
        r_next.sda_p = {r_reg.sda_p[1:0], SDA_IN};
        scl_high  = r_reg.scl_p[1] & r_reg.scl_p[2];
        scl_rise  = r_reg.scl_p[1] & ~r_reg.scl_p[2];
        scl_fall  = ~r_reg.scl_p[1] & r_reg.scl_p[2];
        bus_start = scl_high & ~r_reg.sda_p[1] & r_reg.sda_p[2];
        bus_stop  = scl_high & r_reg.sda_p[1] & ~r_reg.sda_p[2];

        // Measurement results latch as a group
        if (RESULT_LOAD) begin
            r_next.ch0  = LIGHT_CH0;
            r_next.ch1  = LIGHT_CH1;
            r_next.prox = PROX_RESULT;
        end

        ////////////////////////////////////////////////////////////////////
        // Serial slave; start and stop win over clock edges
        if (bus_start) begin
            r_next.bus_st   = SB_ADDR;
            r_next.bit_cnt  = 4'h0;
            r_next.sda_oe_b = 1'b1;
        end else if (bus_stop) begin
            r_next.bus_st   = SB_IDLE;
            r_next.sda_oe_b = 1'b1;
        end else if (scl_rise) begin
            // Sample the data line
            case (r_reg.bus_st)
                SB_ADDR, SB_REG, SB_WDATA: begin
                    r_next.shift   = {r_reg.shift[6:0], r_reg.sda_p[1]};
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                end
                SB_RDATA: begin
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                end
                SB_RACK: begin
                    r_next.nack = r_reg.sda_p[1];
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // Change the data line while the clock is low
            case (r_reg.bus_st)
                SB_ADDR: begin
                    if (r_reg.bit_cnt == 4'h8) begin
                        if (r_reg.shift[7:1] == DEV_ADDR) begin
                            r_next.rw       = r_reg.shift[0];
                            r_next.sda_oe_b = 1'b0;
                            r_next.bus_st   = SB_ADDR_ACK;
                        end else begin
                            // Not for us: wait for the next start
                            r_next.bus_st = SB_IDLE;
                        end
                    end
                end
                SB_ADDR_ACK: begin
                    r_next.bit_cnt = 4'h0;
                    if (r_reg.rw) begin
                        // Fetch first byte from the held pointer
                        rd_fire         = 1'b1;
                        r_next.tx       = rd_byte;
                        r_next.sda_oe_b = rd_byte[7];
                        r_next.ptr      = ptr_step(r_reg.ptr);
                        r_next.bus_st   = SB_RDATA;
                    end else begin
                        r_next.sda_oe_b = 1'b1;
                        r_next.bus_st   = SB_REG;
                    end
                end
                SB_REG: begin
                    if (r_reg.bit_cnt == 4'h8) begin
                        r_next.ptr      = r_reg.shift;
                        r_next.sda_oe_b = 1'b0;
                        r_next.bus_st   = SB_REG_ACK;
                    end
                end
                SB_REG_ACK, SB_WACK: begin
                    r_next.sda_oe_b = 1'b1;
                    r_next.bit_cnt  = 4'h0;
                    r_next.bus_st   = SB_WDATA;
                end
                SB_WDATA: begin
                    // Acknowledged but never stored
                    if (r_reg.bit_cnt == 4'h8) begin
                        r_next.sda_oe_b = 1'b0;
                        r_next.ptr      = ptr_step(r_reg.ptr);
                        r_next.bus_st   = SB_WACK;
                    end
                end
                SB_RDATA: begin
                    if (r_reg.bit_cnt == 4'h8) begin
                        // Let the host acknowledge
                        r_next.sda_oe_b = 1'b1;
                        r_next.bus_st   = SB_RACK;
                    end else begin
                        r_next.tx       = {r_reg.tx[6:0], 1'b0};
                        r_next.sda_oe_b = r_reg.tx[6];
                    end
                end
                SB_RACK: begin
                    r_next.bit_cnt = 4'h0;
                    if (r_reg.nack) begin
                        r_next.sda_oe_b = 1'b1;
                        r_next.bus_st   = SB_IDLE;
                    end else begin
                        // Burst read continues at the stepped pointer
                        rd_fire         = 1'b1;
                        r_next.tx       = rd_byte;
                        r_next.sda_oe_b = rd_byte[7];
                        r_next.ptr      = ptr_step(r_reg.ptr);
                        r_next.bus_st   = SB_RDATA;
                    end
                end
                default: begin
                    r_next.sda_oe_b = 1'b1;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Dataset storage
        {in_last, in_invalid, in_sample} = xf.data;
        take  = xf.valid & xf.ready;
        // Full storage drops the word rather than overwrite
        store = take & (r_reg.count != CNT_W'(BUF_DEPTH));
        // Only the west byte completes a dataset
        pop   = rd_fire & (rd_addr == ADDR_WEST_SAMPLE)
                & (r_reg.count != '0);

        if (store) begin
            r_next.mem[r_reg.wr_ptr] = in_sample;
            r_next.wr_ptr            = r_reg.wr_ptr + PTR_W'(1);
            r_next.invalid           = in_invalid;
        end
        if (pop) begin
            r_next.rd_ptr = r_reg.rd_ptr + PTR_W'(1);
        end
        r_next.count = r_reg.count + CNT_W'(store) - CNT_W'(pop);

        // New data sets the flag even in the cycle it is read
        if (store) begin
            r_next.fresh = 1'b1;
        end else if (pop) begin
            r_next.fresh = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////
        // Motion event sequencing
        case (r_reg.mot_st)
            MOT_COLLECT: begin
                if (take && in_last) begin
                    r_next.irq    = 1'b1;
                    r_next.mot_st = MOT_HOLD;
                end
            end
            MOT_HOLD: begin
                // Held until the host has drained everything
                if (r_reg.count == '0) begin
                    r_next.irq    = 1'b0;
                    r_next.mot_st = MOT_COLLECT;
                end
            end
            default: begin
                r_next.mot_st = MOT_COLLECT;
            end
        endcase
        r_next.active   = (r_next.mot_st == MOT_COLLECT);
        r_next.int_oe_b = ~r_next.irq;
    end

    // Detection stalls the front end while the host drains
    assign xf.ready = (r_reg.mot_st == MOT_COLLECT);

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            r_reg          <= '0;
            r_reg.scl_p    <= 3'b111;
            r_reg.sda_p    <= 3'b111;
            r_reg.sda_oe_b <= 1'b1;
            r_reg.int_oe_b <= 1'b1;
            r_reg.active   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; open-drain pins only ever pull low
    assign SDA_OUT       = 1'b0;
    assign SDA_OE_B      = r_reg.sda_oe_b;
    assign INT_OUT       = 1'b0;
    assign INT_OE_B      = r_reg.int_oe_b;
    assign MOTION_ACTIVE = r_reg.active;

endmodule

`default_nettype wire

//--- tb/srfo_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Pin relations of the readout top
module srfo_checker (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // Serial and interrupt pins
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_B,
    input wire logic INT_OUT,
    input wire logic INT_OE_B,
    // Detection state
    input wire logic MOTION_ACTIVE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////
    // Open drain pins never drive high
    a_sda_low_only: assert property (!SDA_OUT) else $error("sda drives high");
    a_int_low_only: assert property (!INT_OUT) else $error("int drives high");
    // Data bit stands while the clock is high
    a_sda_hold_high: assert property (SCL_IN [*4] |-> $stable(SDA_OE_B))
        else $error("sda moved with scl high");
    // Answer lands well inside the low phase
    a_sda_move_low: assert property ($changed(SDA_OE_B) |-> !SCL_IN && !$past(SCL_IN, 2))
        else $error("sda moved too early");
    // Interrupt and hold go together
    a_irq_stop_mot: assert property ($fell(INT_OE_B) |-> ##[0:2] !MOTION_ACTIVE)
        else $error("irq while collecting");
    a_mot_stop_irq: assert property ($fell(MOTION_ACTIVE) |-> ##[0:2] !INT_OE_B)
        else $error("hold without irq");
    a_drain_restart: assert property ($rose(INT_OE_B) |-> ##[0:2] MOTION_ACTIVE)
        else $error("no restart after drain");
    a_restart_clr: assert property ($rose(MOTION_ACTIVE) |-> ##[0:2] INT_OE_B)
        else $error("restart with irq set");
    // Clear follows a byte fetch, in a low phase
    a_irq_clr_read: assert property ($rose(INT_OE_B) |-> !SCL_IN)
        else $error("irq cleared off a read");
endmodule
`default_nettype wire

//--- tb/srfo_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Serial host; line has a pull-up
module srfo_host_model (
    // Timing and device pull
    input  wire logic clk,
    input  wire logic sda_oe_b,
    // Bus lines
    output logic      scl,
    output wire logic sda
);
    logic       drv = 1'h1; // Host pull, high = released
    logic       nak;        // Some byte went unacked
    logic [7:0] rx [128];   // Bytes read back
    // Low if either side pulls
    assign sda = drv & sda_oe_b;
    initial scl = 1'h1;
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Steps of {sda, scl}: start and stop patterns
    task automatic pins(input logic [7:0] p);
        for (int k = 6; k >= 0; k -= 2) begin
            {drv, scl} = p[k+:2];
            tk(4);
        end
    endtask
    // SDA moves only with SCL low
    task automatic bt(input logic b, output logic r);
        drv = b;
        tk(8);
        scl = 1'h1;
        tk(4);
        r = sda;
        tk(4);
        scl = 1'h0;
    endtask
    task automatic wb(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bt(b[i], r);
        bt(1'h1, r);
        nak |= r;
    endtask
    // Pointer write, then a data byte, or repeated start and read
    task automatic xfer(input logic [7:0] ra, wd, input int n, input logic wr);
        logic a;
        nak = 1'h0;
        pins(8'hB4);
        wb(8'h46);
        wb(ra);
        if (wr) wb(wd);
        else begin
            pins(8'hB4);
            wb(8'h47);
            for (int j = 0; j < n; j++) begin
                for (int i = 7; i >= 0; i--) bt(1'h1, rx[j][i]);
                bt(j == n - 1, a);
            end
        end
        pins(8'h1F);
    endtask
endmodule
`default_nettype wire

//--- tb/sensor_result_readout_fifo_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_result_readout_fifo_tb;
    import srfo_pkg::*;
    typedef struct {logic [7:0] a, l;} srfo_row_t;
    // Address and value once results are loaded
    srfo_row_t rows [9] = '{'{8'h9E, 8'h00}, '{8'hA4, 8'h34}, '{8'hA5, 8'h12}, '{8'hA6, 8'h78},
        '{8'hA7, 8'h56}, '{8'hB0, 8'hA9}, '{8'hB1, 8'h05}, '{8'hB2, 8'h00}, '{8'h20, 8'h00}};
    logic clk_sys = 0, link_clk = 0, rst_b = 0, fe_valid = 0, fe_inv = 0, fe_last = 0, load = 0;
    logic [31:0] fe_sample = 32'h0000_0000;
    logic scl, sda_out, sda_oe_b, int_out, int_oe_b, fe_ready, mot_act;
    wire logic sda;
    int fail_count = 0;
    int samples_checked = 0;
    initial forever #2 clk_sys = ~clk_sys;
    // Link clock, unrelated phase
    initial begin
        #17;
        forever #62.5 link_clk = ~link_clk;
    end
    srfo_host_model host (.clk(clk_sys), .sda_oe_b(sda_oe_b), .scl(scl), .sda(sda));
    srfo_readout uut (.CLK_SYS(clk_sys), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b), .INT_OUT(int_out), .INT_OE_B(int_oe_b),
        .LINK_CLK(link_clk), .FE_VALID(fe_valid), .FE_SAMPLE(fe_sample), .FE_INVALID(fe_inv),
        .FE_LAST(fe_last), .FE_READY(fe_ready), .LIGHT_CH0(16'h1234), .LIGHT_CH1(16'h5678),
        .PROX_RESULT(11'h5A9), .RESULT_LOAD(load), .MOTION_ACTIVE(mot_act));
    ////////////////////////////////////////
    task automatic stop_test;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, e, input string n);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // A used-up wait counts as a mismatch, then ends the run
    task automatic tmo;
        fail_count++;
        stop_test;
    endtask
    task automatic rc(input logic [7:0] a, e);
        host.xfer(a, 8'h00, 1, 1'h0);
        chk(host.rx[0], e, "register");
        chk({7'h00, host.nak}, 8'h00, "ack");
    endtask
    // Word held until a link edge sees ready
    task automatic fe_send(input int i, input logic inv, lst);
        @(negedge link_clk);
        {fe_valid, fe_inv, fe_last} = {1'h1, inv, lst};
        fe_sample = {8'(i + 48), 8'(i + 32), 8'(i + 16), 8'(i)};
        for (int k = 0; fe_ready !== 1'h1; k++) begin
            if (k > 400) tmo;
            @(negedge link_clk);
        end
        @(posedge link_clk);
        fe_valid <= 1'h0;
    endtask
    // Bounded wait on the interrupt pin
    task automatic wirq(input logic lvl);
        for (int k = 0; int_oe_b !== lvl; k++) begin
            if (k > 20000) tmo;
            @(negedge clk_sys);
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(negedge link_clk);
        rst_b = 1'h1;
        repeat (4) @(negedge clk_sys);
        chk({5'h00, fe_ready, int_oe_b, mot_act}, 8'h07, "pins");
        for (int p = 0; p < 2; p++) begin
            @(negedge clk_sys) load = p[0];
            @(negedge clk_sys) load = 1'h0;
            foreach (rows[i]) rc(rows[i].a, p ? rows[i].l : RST_BYTE);
        end
        host.xfer(8'hA4, 8'hFF, 0, 1'h1);
        rc(8'hA4, 8'h34);
        fe_send(1, 1'h0, 1'h0);
        fe_send(2, 1'h1, 1'h1);
        wirq(1'h0);
        rc(8'h9E, 8'hB8);
        host.xfer(8'hB3, 8'h00, 3, 1'h0);
        rc(8'hB2, 8'h02);
        for (int d = 1; d < 3; d++) begin
            host.xfer(8'hB3, 8'h00, 4, 1'h0);
            for (int b = 0; b < 4; b++) chk(host.rx[b], 8'(d + 16 * b), "sample");
            rc(8'hB2, 8'(2 - d));
        end
        wirq(1'h1);
        repeat (4) @(negedge clk_sys);
        chk({7'h00, mot_act}, 8'h01, "restart");
        rc(8'h9E, 8'h20);
        for (int i = 1; i < 35; i++) fe_send(i, 1'h0, i == 34);
        wirq(1'h0);
        rc(8'h9E, 8'hD8);
        rc(8'hB2, 8'h20);
        host.xfer(8'hB3, 8'h00, 128, 1'h0);
        for (int k = 0; k < 128; k++) chk(host.rx[k], 8'(k / 4 + 1 + 16 * (k % 4)), "drain");
        wirq(1'h1);
        rc(8'h9E, 8'h00);
        stop_test;
    end
endmodule
bind srfo_readout srfo_checker chk_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_B(SDA_OE_B), .INT_OUT(INT_OUT), .INT_OE_B(INT_OE_B), .MOTION_ACTIVE(MOTION_ACTIVE));
`default_nettype wire
